// *** rtl/adcsq_core.sv ***
// Purpose: control, sequencing and result handling of a 10-bit converter
// Assumes: analog core result is valid whenever the period ends
// Notes:   wishbone classic slave, ack one cycle after the strobe
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "adcsq_map.svh"

// Behaviour
// RULE1: standby resets control two except time, second_idle_mode
// RULE2: high result read clears done flag
// RULE3: busy high during each conversion
// RULE4: time codes give 78 to 1248 cycles
// RULE5: software picks time of 15.6 us
// RULE6: 8-bit mode: high byte holds bits 9:2
// RULE7: 10-bit mode: high byte holds bits 9:8
// RULE8: single mode start converts selected channel
// RULE9: completion stores result, sets flag, interrupts
// RULE10: start bit clears once conversion begins
// RULE11: software waits for done before restart
// RULE12: repeat mode chains conversions back to back
// RULE13: mode 00 aborts, result discarded
// RULE14: new start clears flag, keeps old result
// RULE15: standby aborts, resets controls, clears result
// RULE16: no automatic restart after standby
// RULE17: second_idle_mode follows second idle run bit
// RULE18: standby disconnects reference ladder
// RULE19: software reads low byte before high
// RULE20: result is 10-bit unsigned code
// RULE21: software avoids port traffic during conversion
// RULE22: control one: start, mode, enable, channel
// RULE23: format bit 0 ten-bit, 1 eight-bit
// RULE24: count period then take analog result
module adcsq_core
  import adcsq_pkg::*;
#(
  parameter int RW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [13:0]   wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic [RW-1:0] analog_result_i,
  output logic               sample_en_o,
  output logic [3:0]         channel_o,
  output logic               analog_input_enable_o,
  output logic               ladder_connect_o,
  output logic               conversion_done_interrupt_o
);

  adcsq_wb_req_t req;
  adcsq_ctrl1_t  ctrl1_q;
  adcsq_state_t  state_q;
  adcsq_pwr_t    pwr_q;
  logic          done_q;
  logic          busy_q;
  logic          fmt_q;
  logic          second_idle_mode_run_q;
  logic [3:0]    time_q;
  logic [RW-1:0] result_q;
  logic          wr_c1;
  logic          wr_c2;
  logic          wr_pw;
  logic          rd_hi;
  logic          access;
  logic          standby;
  logic          halted;
  logic          mode_off;
  logic          launch;
  logic          conv_end;
  logic [7:0]    res_lo;
  logic [7:0]    res_hi;

  // gather bus signals into one request
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // a request is taken in the cycle it first appears, ack not yet given
  assign access = req.cyc && req.stb && !wb_ack_o;
  assign wr_c1  = access && req.we && req.sel[0] && (req.adr == `ADCSQ_ADDR_CTRL1);
  assign wr_c2  = access && req.we && req.sel[0] && (req.adr == `ADCSQ_ADDR_CTRL2);
  assign wr_pw  = access && req.we && req.sel[0] && (req.adr == `ADCSQ_ADDR_POWER);
  assign rd_hi  = access && !req.we && (req.adr == `ADCSQ_ADDR_RES_HI);

  // stop and first idle act as standby; second_idle_mode halts unless enabled
  assign standby  = (pwr_q == ADCSQ_PWR_STOP) || (pwr_q == ADCSQ_PWR_FIRST_IDLE_MODE);
  assign halted   = standby || ((pwr_q == ADCSQ_PWR_SECOND_IDLE_MODE) && !second_idle_mode_run_q); // RULE17
  assign mode_off = wr_c1 && (adcsq_mode_t'(req.dat[`ADCSQ_C1_MODE_HI:`ADCSQ_C1_MODE_LO]) == ADCSQ_MODE_OFF);

  // a start is honoured in the cycle after the start bit is written
  assign launch = ctrl1_q.start && !halted && (state_q == ADCSQ_ST_IDLE || state_q == ADCSQ_ST_DONE)
                  && (ctrl1_q.mode == ADCSQ_MODE_SINGLE || ctrl1_q.mode == ADCSQ_MODE_REPEAT); // RULE8

  // result byte layouts
  function automatic logic [7:0] hi_byte(input logic [RW-1:0] r, input logic eight);
    hi_byte = eight ? r[RW-1:2] : {6'h00, r[RW-1:RW-2]};
  endfunction : hi_byte

  assign res_lo = result_q[7:0]; // RULE7
  assign res_hi = hi_byte(result_q, fmt_q); // RULE6 RULE7 RULE23

  // conversion period counter
  adcsq_timer #(
    .CW (11)
  ) u_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state_q == ADCSQ_ST_CONV && !halted && !mode_off),
    .code_i (time_q),
    .done_o (conv_end)
  );

  // power state register, written by the system controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= ADCSQ_PWR_NORMAL;
    end else if (wr_pw) begin
      pwr_q <= adcsq_pwr_t'(req.dat[`ADCSQ_PWR_HI:`ADCSQ_PWR_LO]);
    end
  end

  // control one: standby resets all but channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_q <= adcsq_ctrl1_t'(`ADCSQ_RST_CTRL1);
    end else if (standby) begin
      ctrl1_q.start  <= 1'b0; // RULE15 RULE16
      ctrl1_q.mode   <= ADCSQ_MODE_OFF;
      ctrl1_q.ain_en <= 1'b0;
    end else if (wr_c1) begin
      ctrl1_q <= adcsq_ctrl1_t'(req.dat[7:0]); // RULE22
    end else if (launch) begin
      ctrl1_q.start <= 1'b0; // RULE10
    end
  end

  // control two writable fields; standby keeps time and second_idle_mode bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt_q       <= 1'b0;
      second_idle_mode_run_q <= 1'b0;
      time_q      <= `ADCSQ_RST_TIME;
    end else if (standby) begin
      fmt_q <= 1'b0; // RULE1
    end else if (wr_c2) begin
      fmt_q       <= req.dat[`ADCSQ_C2_FMT]; // RULE23
      second_idle_mode_run_q <= req.dat[`ADCSQ_C2_SECOND_IDLE_MODE];
      time_q      <= req.dat[`ADCSQ_C2_TIME_HI:`ADCSQ_C2_TIME_LO];
    end
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ADCSQ_ST_IDLE;
    end else if (standby || mode_off) begin
      state_q <= ADCSQ_ST_IDLE; // RULE13 RULE15
    end else begin
      case (state_q)
        ADCSQ_ST_IDLE: begin
          if (launch) begin
            state_q <= ADCSQ_ST_CONV;
          end
        end
        ADCSQ_ST_CONV: begin
          if (conv_end) begin
            state_q <= (ctrl1_q.mode == ADCSQ_MODE_REPEAT) ? ADCSQ_ST_CONV : ADCSQ_ST_DONE; // RULE12
          end
        end
        ADCSQ_ST_DONE: begin
          if (launch) begin
            state_q <= ADCSQ_ST_CONV;
          end
        end
        default: begin
          state_q <= ADCSQ_ST_IDLE;
        end
      endcase
    end
  end

  // busy flag
  always_ff @(posedge clk_i) begin
    if (rst_i || standby || mode_off) begin
      busy_q <= 1'b0;
    end else if (launch) begin
      busy_q <= 1'b1; // RULE3
    end else if (conv_end && ctrl1_q.mode != ADCSQ_MODE_REPEAT) begin
      busy_q <= 1'b0; // RULE3
    end
  end

  // done flag: completion wins over a read clear
  always_ff @(posedge clk_i) begin
    if (rst_i || standby) begin
      done_q <= 1'b0;
    end else if (conv_end && !mode_off) begin
      done_q <= 1'b1; // RULE9
    end else if (rd_hi || launch) begin
      done_q <= 1'b0; // RULE2 RULE14
    end
  end

  // result store only on completion; standby leaves it cleared
  always_ff @(posedge clk_i) begin
    if (rst_i || standby) begin
      result_q <= RW'(`ADCSQ_RST_RESULT); // RULE15
    end else if (conv_end && !mode_off) begin
      result_q <= analog_result_i; // RULE9 RULE20 RULE24
    end
  end

  // interrupt pulse together with the store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_done_interrupt_o <= 1'b0;
    end else begin
      conversion_done_interrupt_o <= conv_end && !mode_off && !standby; // RULE9
    end
  end

  // analog side controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_en_o           <= 1'b0;
      channel_o             <= 4'h0;
      analog_input_enable_o <= 1'b0;
      ladder_connect_o      <= 1'b0;
    end else begin
      sample_en_o           <= (state_q == ADCSQ_ST_CONV) && !halted;
      channel_o             <= ctrl1_q.channel;
      analog_input_enable_o <= ctrl1_q.ain_en;
      ladder_connect_o      <= !halted && (ctrl1_q.mode != ADCSQ_MODE_OFF); // RULE18
    end
  end

  // bus answer: one-cycle ack, read data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= 32'h0000_0000;
      if (access && !req.we) begin
        case (req.adr)
          `ADCSQ_ADDR_CTRL1:  wb_dat_o[7:0] <= ctrl1_q;
          `ADCSQ_ADDR_CTRL2:  wb_dat_o[7:0] <= {done_q, busy_q, fmt_q, second_idle_mode_run_q, time_q};
          `ADCSQ_ADDR_RES_LO: wb_dat_o[7:0] <= res_lo;
          `ADCSQ_ADDR_RES_HI: wb_dat_o[7:0] <= res_hi;
          `ADCSQ_ADDR_POWER:  wb_dat_o[7:0] <= {6'h00, pwr_q};
          default:            wb_dat_o[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // checks: a high read clears the done flag unless a completion lands with it
  a_hi_read_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    (rd_hi && !conv_end) |=> !done_q) else $error("done flag not cleared by high read");

  // busy rises with every honoured start
  a_busy_launch: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    (launch && !standby && !mode_off) |=> busy_q) else $error("busy not set on start");

  // busy falls when a non-repeating conversion ends
  a_busy_end: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    (conv_end && ctrl1_q.mode != ADCSQ_MODE_REPEAT) |=> !busy_q) else $error("busy not cleared at end");

  // start bit drops once the conversion is under way
  a_start_self_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    (launch && !wr_c1 && !standby) |=> !ctrl1_q.start) else $error("start bit not cleared");

  // a single-mode start enters the conversion and drives the sampler next
  a_single_start: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    (launch && ctrl1_q.mode == ADCSQ_MODE_SINGLE && !mode_off && !wr_pw)
    |=> (state_q == ADCSQ_ST_CONV) ##1 sample_en_o) else $error("single start did not convert");

  // completion stores, flags and interrupts in the same cycle
  a_store_flag_irq: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    (conv_end && !mode_off && !standby) |=> (done_q && conversion_done_interrupt_o
      && result_q == $past(analog_result_i))) else $error("completion effects not together");

  // the interrupt is a single-cycle pulse
  a_irq_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    conversion_done_interrupt_o |=> !conversion_done_interrupt_o) else $error("interrupt longer than one cycle");

  // an abort keeps the stored result and idles the sequencer
  a_abort_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (mode_off && !standby) |=> ($stable(result_q) && !busy_q && state_q == ADCSQ_ST_IDLE))
    else $error("abort changed result");

  // a restart clears the flag but leaves the old result in place
  a_restart_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    launch |=> (!done_q && $stable(result_q))) else $error("restart lost old result");

  // standby resets control two except time and second idle bit
  a_standby_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    standby |=> (!fmt_q && !done_q && !busy_q && ctrl1_q.mode == ADCSQ_MODE_OFF && $stable(time_q)))
    else $error("standby did not reset controls");

  // standby discards the result and stops the sampler
  a_standby_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
    standby |=> (result_q == RW'(`ADCSQ_RST_RESULT) && !sample_en_o)) else $error("standby kept result");

  // standby disconnects the reference ladder
  a_ladder_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
    standby |=> !ladder_connect_o) else $error("ladder still connected in standby");

  // repeat mode goes straight into the next conversion
  a_repeat_chain: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    (conv_end && ctrl1_q.mode == ADCSQ_MODE_REPEAT && !halted && !mode_off) |=> state_q == ADCSQ_ST_CONV)
    else $error("repeat did not chain");

  // ten-bit layout of the high byte as answered on the bus
  a_hi_layout: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    (rd_hi && !fmt_q) |=> wb_dat_o[7:0] == {6'h00, $past(result_q[RW-1:RW-2])})
    else $error("high byte wrong in ten-bit mode");

  // eight-bit layout of the high byte as answered on the bus
  a_hi_eight: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    (rd_hi && fmt_q) |=> wb_dat_o[7:0] == $past(result_q[RW-1:2]))
    else $error("high byte wrong in eight-bit mode");

  // leaving standby never restarts a conversion
  a_no_resume: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    standby ##1 !standby |-> state_q == ADCSQ_ST_IDLE) else $error("resumed after standby");

  // halted second idle stops the sampler and the period count
  a_second_idle_mode_halt: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
    (pwr_q == ADCSQ_PWR_SECOND_IDLE_MODE && !second_idle_mode_run_q) |=> (!sample_en_o && !conv_end))
    else $error("converter ran in halted second idle");

  // running second idle keeps the conversion going
  a_second_idle_mode_runs: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
    (pwr_q == ADCSQ_PWR_SECOND_IDLE_MODE && second_idle_mode_run_q && state_q == ADCSQ_ST_CONV) |=> sample_en_o)
    else $error("converter stopped in running second idle");

  // control one takes the written byte
  a_ctrl1_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    (wr_c1 && !standby) |=> ctrl1_q == $past(wb_dat_i[7:0])) else $error("control one write lost");

  // format bit follows a control two write
  a_fmt_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
    (wr_c2 && !standby) |=> fmt_q == $past(wb_dat_i[`ADCSQ_C2_FMT])) else $error("format bit write lost");

endmodule : adcsq_core

// *** rtl/adcsq_map.svh ***
// Purpose: register offsets, field positions, reset values and timing codes of the converter sequencer
// Assumes: byte-wide registers mapped onto aligned 32-bit wishbone words
// Notes:   definitions only
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH

// register indices and byte addresses
`define ADCSQ_IDX_CTRL1    12'h2B0
`define ADCSQ_IDX_CTRL2    12'h2B1
`define ADCSQ_IDX_RES_LO   12'h2B2
`define ADCSQ_IDX_RES_HI   12'h2B3
`define ADCSQ_IDX_POWER    12'h2B4
`define ADCSQ_ADDR_CTRL1   14'h0AC0
`define ADCSQ_ADDR_CTRL2   14'h0AC4
`define ADCSQ_ADDR_RES_LO  14'h0AC8
`define ADCSQ_ADDR_RES_HI  14'h0ACC
`define ADCSQ_ADDR_POWER   14'h0AD0

// control one fields
`define ADCSQ_C1_START     7
`define ADCSQ_C1_MODE_HI   6
`define ADCSQ_C1_MODE_LO   5
`define ADCSQ_C1_ANALOG_INPUT_ENABLE     4
`define ADCSQ_C1_CH_HI     3
`define ADCSQ_C1_CH_LO     0

// control two fields
`define ADCSQ_C2_DONE      7
`define ADCSQ_C2_BUSY      6
`define ADCSQ_C2_FMT       5
`define ADCSQ_C2_SECOND_IDLE_MODE     4
`define ADCSQ_C2_TIME_HI   3
`define ADCSQ_C2_TIME_LO   0

// reset values
`define ADCSQ_RST_CTRL1    8'h00
`define ADCSQ_RST_TIME     4'hC
`define ADCSQ_RST_RESULT   10'h000

// power mode register: bits 1:0 select the chip power state
`define ADCSQ_PWR_HI       1
`define ADCSQ_PWR_LO       0

// conversion-time codes and their cycle counts
`define ADCSQ_TIME_78      4'hA
`define ADCSQ_TIME_156     4'hB
`define ADCSQ_TIME_312     4'hC
`define ADCSQ_TIME_624     4'hD
`define ADCSQ_TIME_1248    4'hE
`define ADCSQ_CYC_78       11'h04E
`define ADCSQ_CYC_156      11'h09C
`define ADCSQ_CYC_312      11'h138
`define ADCSQ_CYC_624      11'h270
`define ADCSQ_CYC_1248     11'h4E0
`define ADCSQ_CYC_NONE     11'h000

`endif

// *** rtl/adcsq_pkg.sv ***
// Purpose: shared types of the converter sequencer
// Assumes: used together with adcsq_map.svh
// Notes:   no constants here, only types
package adcsq_pkg;

  // operating mode encodings
  typedef enum logic [1:0] {
    ADCSQ_MODE_OFF    = 2'h0,
    ADCSQ_MODE_SINGLE = 2'h1,
    ADCSQ_MODE_RSVD   = 2'h2,
    ADCSQ_MODE_REPEAT = 2'h3
  } adcsq_mode_t;

  // chip power states seen by the block
  typedef enum logic [1:0] {
    ADCSQ_PWR_NORMAL = 2'h0,
    ADCSQ_PWR_SECOND_IDLE_MODE  = 2'h1,
    ADCSQ_PWR_FIRST_IDLE_MODE  = 2'h2,
    ADCSQ_PWR_STOP   = 2'h3
  } adcsq_pwr_t;

  // sequencer states
  typedef enum logic [1:0] {
    ADCSQ_ST_IDLE = 2'h0,
    ADCSQ_ST_CONV = 2'h1,
    ADCSQ_ST_DONE = 2'h2
  } adcsq_state_t;

  // wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [13:0] adr;
    logic [31:0] dat;
  } adcsq_wb_req_t;

  // control one contents
  typedef struct packed {
    logic        start;
    adcsq_mode_t mode;
    logic        ain_en;
    logic [3:0]  channel;
  } adcsq_ctrl1_t;

endpackage : adcsq_pkg

// *** rtl/adcsq_timer.sv ***
// Purpose: conversion period counter
// Assumes: code maps to a cycle count; reserved codes give zero
// Notes:   done pulses once when the count reaches the period
`timescale 1ns/100ps
`include "adcsq_map.svh"
module adcsq_timer
  import adcsq_pkg::*;
#(
  parameter int CW = 11
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          run_i,
  input  wire logic [3:0]    code_i,
  output logic               done_o
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] period;

  // decode the time code to a cycle count
  function automatic logic [CW-1:0] period_of(input logic [3:0] c);
    case (c)
      `ADCSQ_TIME_78:   period_of = CW'(`ADCSQ_CYC_78);
      `ADCSQ_TIME_156:  period_of = CW'(`ADCSQ_CYC_156);
      `ADCSQ_TIME_312:  period_of = CW'(`ADCSQ_CYC_312);
      `ADCSQ_TIME_624:  period_of = CW'(`ADCSQ_CYC_624);
      `ADCSQ_TIME_1248: period_of = CW'(`ADCSQ_CYC_1248);
      default:          period_of = CW'(`ADCSQ_CYC_NONE);
    endcase
  endfunction : period_of

  assign period = period_of(code_i); // RULE4

  // count while running, restart on stop; reserved codes never finish
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || done_o) begin
      cnt_q  <= '0;
      done_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      done_o <= (period != '0) && (cnt_q + CW'(1) == period - CW'(1)); // RULE24
    end
  end

endmodule : adcsq_timer

// *** tb/adcsq_analog_model.sv ***
// Purpose: behavioural analog core that hands codes to the sequencer
// Assumes: the bench sets the input level of the selected channel
// Notes:   outside a conversion the code is inverted so stale data shows
`timescale 1ns/100ps
module adcsq_analog_model (
  input  wire logic       clk_i,
  input  wire logic       sample_en_i,
  input  wire logic [9:0] level_i,
  output logic [9:0]      code_o
);
  logic hold_q;

  // keep the code valid one cycle past the end of a conversion
  always_ff @(posedge clk_i) begin
    hold_q <= sample_en_i;
  end

  // 10-bit unsigned code while converting and for one cycle after
  assign code_o = (sample_en_i | hold_q) ? level_i : ~level_i;
endmodule : adcsq_analog_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the converter sequencer
// Assumes: one wishbone master, reads checked from a queue by a monitor
// Notes:   fast time codes appear only in the timing sweep
`timescale 1ns/100ps
`include "adcsq_map.svh"
module tb_top import adcsq_pkg::*;;
  logic          clk_i;
  logic          rst_i;
  adcsq_wb_req_t req;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o, sample_en_o, ana_en, ladder, irq;
  logic [3:0]    chan, ch;
  logic [9:0]    level, code, v, v2;
  logic [7:0]    c2;
  logic [15:0]   exp_q[$];
  logic [31:0]   seed;
  int            miscompares, comparisons, irq_cnt, starts, hi_len, lo_len, last_len, max_gap, n;

  adcsq_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .analog_result_i(code), .sample_en_o(sample_en_o), .channel_o(chan), .analog_input_enable_o(ana_en),
    .ladder_connect_o(ladder), .conversion_done_interrupt_o(irq));
  adcsq_analog_model ana (.clk_i(clk_i), .sample_en_i(sample_en_o), .level_i(level), .code_o(code));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check

  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // one classic cycle; a read notes its expected byte and mask
  task wb(input logic w, input logic [13:0] a, input logic [7:0] d, input logic [7:0] m = 8'hFF);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a, dat: {24'h0, d}};
    if (!w) exp_q.push_back({m, d});
    @(posedge clk_i);
    // hold the request until ack; only the watchdog ends a hung wait
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    req <= '0;
    @(posedge clk_i);
  endtask : wb

  task wait_irq(input int lim, input logic want);
    int c0;
    c0 = irq_cnt;
    repeat (lim) begin
      @(posedge clk_i);
      if (irq_cnt != c0) break;
    end
    check(irq_cnt != c0, want);
  endtask : wait_irq

  task start(input logic [7:0] cfg2, input logic [3:0] m1);
    wb(1'b1, `ADCSQ_ADDR_CTRL2, cfg2);
    wb(1'b1, `ADCSQ_ADDR_CTRL1, {m1, ch});
  endtask : start

  // clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // read monitor: oldest note against each read answer
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && !req.we && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      check(wb_dat_o & {24'hFFFFFF, n[15:8]}, {24'h0, n[7:0] & n[15:8]});
    end
  end

  // interrupt count and conversion lengths
  always @(posedge clk_i) begin
    if (irq === 1'b1) irq_cnt++;
    if (sample_en_o === 1'b1) begin
      if (hi_len == 0) starts++;
      if (hi_len == 0 && lo_len > max_gap) max_gap = lo_len;
      hi_len++;
      lo_len = 0;
    end else begin
      if (hi_len != 0) last_len = hi_len;
      hi_len = 0;
      lo_len++;
    end
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    give_verdict;
  end

  // main sequence
  initial begin
    req = '0;
    rst_i = 1'b1;
    level = 10'h000;
    seed = 32'h5B9C1E41;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `ADCSQ_ADDR_CTRL1, 8'h00);
    wb(1'b0, `ADCSQ_ADDR_CTRL2, 8'h0C);
    wb(1'b1, `ADCSQ_ADDR_RES_LO, 8'h5A);
    wb(1'b0, `ADCSQ_ADDR_RES_LO, 8'h00);
    wb(1'b0, `ADCSQ_ADDR_RES_HI, 8'h00);
    wb(1'b0, 14'h0000, 8'h00);
    // single conversions, ten-bit then eight-bit storing
    for (int f = 0; f < 2; f++) begin
      seed = xorshift(seed);
      ch = seed[3:0];
      v = seed[13:4];
      level <= v;
      c2 = f ? 8'h2D : 8'h0D;
      start(c2, 4'hB);
      check({chan, ana_en, ladder}, {ch, 2'h3});
      wb(1'b0, `ADCSQ_ADDR_CTRL1, {4'h3, ch});
      wb(1'b0, `ADCSQ_ADDR_CTRL2, 8'h40 | c2);
      wait_irq(700, 1'b1);
      wb(1'b0, `ADCSQ_ADDR_CTRL2, 8'h80 | c2);
      wb(1'b0, `ADCSQ_ADDR_RES_LO, v[7:0], f ? 8'h00 : 8'hFF);
      wb(1'b0, `ADCSQ_ADDR_RES_HI, f ? v[9:2] : {6'h0, v[9:8]});
      wb(1'b0, `ADCSQ_ADDR_CTRL2, c2);
    end
    // restart before reading keeps the old result
    start(8'h0D, 4'hB);
    wait_irq(700, 1'b1);
    v2 = ~v;
    level <= v2;
    wb(1'b1, `ADCSQ_ADDR_CTRL1, {4'hB, ch});
    wb(1'b0, `ADCSQ_ADDR_CTRL2, 8'h4D);
    wb(1'b0, `ADCSQ_ADDR_RES_LO, v[7:0]);
    wait_irq(700, 1'b1);
    wb(1'b0, `ADCSQ_ADDR_RES_LO, v2[7:0]);
    // repeat mode, then stop in mid-conversion
    wb(1'b1, `ADCSQ_ADDR_CTRL1, {4'hF, ch});
    wait_irq(700, 1'b1);
    max_gap = 0;
    wait_irq(700, 1'b1);
    wait_irq(700, 1'b1);
    check(max_gap <= 2, 1'b1);
    level <= v;
    repeat (100) @(posedge clk_i);
    wb(1'b1, `ADCSQ_ADDR_CTRL1, {4'h1, ch});
    check({sample_en_o, ladder}, 2'h0);
    wait_irq(700, 1'b0);
    wb(1'b0, `ADCSQ_ADDR_RES_LO, v2[7:0]);
    wb(1'b0, `ADCSQ_ADDR_CTRL2, 8'h0D, 8'h7F);
    // period of every valid code, fast codes for timing only
    for (int k = 0; k < 5; k++) begin
      start(8'h0A + k, 4'hB);
      wait_irq(1300, 1'b1);
      repeat (4) @(posedge clk_i);
      check(last_len >= (78 << k) && last_len <= (78 << k) + 2, 1'b1);
    end
    // reserved codes never finish
    for (int k = 0; k < 2; k++) begin
      start(k ? 8'h0F : 8'h09, 4'hB);
      wait_irq(1300, 1'b0);
      wb(1'b1, `ADCSQ_ADDR_CTRL1, {4'h1, ch});
    end
    // forced standby during a conversion, first_idle_mode then stop
    for (int p = 2; p < 4; p++) begin
      start(8'h3D, 4'hB);
      repeat (50) @(posedge clk_i);
      wb(1'b1, `ADCSQ_ADDR_POWER, p[7:0]);
      check({sample_en_o, ladder}, 2'h0);
      wb(1'b0, `ADCSQ_ADDR_CTRL2, 8'h1D);
      wb(1'b1, `ADCSQ_ADDR_POWER, 8'h00);
      wb(1'b0, `ADCSQ_ADDR_CTRL1, 8'h00, 8'hF0);
      wb(1'b0, `ADCSQ_ADDR_RES_LO, 8'h00);
      wb(1'b0, `ADCSQ_ADDR_RES_HI, 8'h00);
      n = starts;
      wait_irq(700, 1'b0);
      check(starts == n, 1'b1);
    end
    // second idle mode, halted then running
    for (int b = 0; b < 2; b++) begin
      start({3'h0, b[0], 4'hD}, 4'hB);
      wb(1'b1, `ADCSQ_ADDR_POWER, 8'h01);
      wait_irq(700, b[0]);
      check(ladder, b[0]);
      wb(1'b1, `ADCSQ_ADDR_POWER, 8'h00);
      if (b == 0) wait_irq(700, 1'b1);
    end
    give_verdict;
  end
endmodule : tb_top
